// file: include/adc_ctrl_map.svh
// Register offsets, field positions, queue depth and timing counts
`ifndef ADC_CTRL_MAP_SVH
`define ADC_CTRL_MAP_SVH
`define OFS_CONTROL_STATUS     6'h00
`define OFS_LATEST_RESULT      6'h04
`define OFS_QUEUE_CTRL         6'h08
`define OFS_QUEUE_DATA         6'h0C
`define OFS_PACING_DIVIDER     6'h10
`define OFS_RAW_INTERRUPT      6'h14
`define OFS_INTERRUPT_ENABLE   6'h18
`define OFS_INTERRUPT_FORCE    6'h1C
`define OFS_INTERRUPT_STATUS   6'h20
`define CS_EN                  0
`define CS_TEMP_BIAS_ENABLE               1
`define CS_START_ONCE          2
`define CS_START_MANY          3
`define CS_READY               8
`define CS_ERR                 9
`define CS_ERR_STICKY          10
`define CS_SEL_LSB             12
`define CS_SEL_MSB             14
`define CS_MASK_LSB            16
`define CS_MASK_MSB            20
`define QC_EN                  0
`define QC_SHIFT               1
`define QC_ERR                 2
`define QC_DREQ_EN             3
`define QC_EMPTY               8
`define QC_FULL                9
`define QC_UNDER               10
`define QC_OVER                11
`define QC_LEVEL_LSB           16
`define QC_LEVEL_MSB           19
`define QC_THRESH_LSB          24
`define QC_THRESH_MSB          27
`define DIV_FRAC_LSB           0
`define DIV_FRAC_MSB           7
`define DIV_INT_LSB            8
`define DIV_INT_MSB            23
`define ENTRY_ERR_BIT          12
`define QUEUE_DEPTH            4
`define CONV_CYCLES            7'd96
`define POWERUP_CYCLES         3'd4
`define TEMP_SELECT            3'h4
`endif

// file: include/adc_ctrl_pkg.sv
// Types shared by the converter control block
`default_nettype none
package adc_ctrl_pkg;
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [5:0]  addr;
    logic [31:0] wdata;
  } reg_req_s;
  typedef struct packed {
    logic        err;
    logic [11:0] data;
  } sample_s;
endpackage : adc_ctrl_pkg
`default_nettype wire

// file: design/adc_sequencer.sv
// Converter sequencer, result queue, pacing and request logic
`include "adc_ctrl_map.svh"
`default_nettype none

module result_queue #(
  parameter int WIDTH = 13,
  parameter int DEPTH = 4
) (
  input  wire logic             clk,
  input  wire logic             arst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic      [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wp_q;
  logic [AW-1:0]    rp_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;

  assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_q[rp_q];
  assign level     = cnt_q;

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wp_q] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wp_q <= (wp_q == AW'(DEPTH - 1)) ? '0 : wp_q + AW'(1);
      end
      if (pop) begin
        rp_q <= (rp_q == AW'(DEPTH - 1)) ? '0 : rp_q + AW'(1);
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : result_queue

module adc_sequencer (
  input  wire logic                     clk,
  input  wire logic                     arst_n,
  input  wire adc_ctrl_pkg::reg_req_s   reg_req,
  output logic                          reg_rvalid,
  output logic [31:0]                   reg_rdata,
  output logic                          converter_power,
  output logic                          temp_bias_enable,
  output logic                          sar_start,
  output logic [2:0]                    sar_select,
  input  wire adc_ctrl_pkg::sample_s    sar_sample,
  output logic                          converter_dma_request,
  output logic                          irq
);
  typedef enum logic [1:0] {ST_OFF, ST_POWERUP, ST_IDLE, ST_BUSY} conv_state_e;

  conv_state_e           state_q;
  logic [2:0]            pwr_cnt_q;
  logic [6:0]            conv_cnt_q;
  logic                  en_q;
  logic                  temp_bias_enable_q;
  logic                  many_q;
  logic [2:0]            input_select_q;
  logic [4:0]            rotation_channel_mask_q;
  logic                  err_q;
  logic                  err_sticky_q;
  logic [11:0]           result_q;
  logic                  queue_write_enable_q;
  logic                  byte_shift_option_q;
  logic                  error_tag_option_q;
  logic                  dma_request_enable_q;
  logic [3:0]            queue_threshold_q;
  logic                  queue_overflow_flag_q;
  logic                  queue_underflow_flag_q;
  logic [15:0]           div_int_q;
  logic [7:0]            div_frac_q;
  logic [16:0]           pace_cnt_q;
  logic [7:0]            pace_acc_q;
  logic                  interrupt_enable_q;
  logic                  interrupt_force_q;
  logic                  sar_start_q;
  logic [31:0]           rdata_q;
  logic                  rvalid_q;

  logic                  wr_cs;
  logic                  wr_qc;
  logic                  wr_div;
  logic                  rd_qdata;
  logic                  ready;
  logic                  done;
  logic                  pace_tick;
  logic                  pace_extra;
  logic                  start;
  logic                  push_req;
  logic                  q_in_ready;
  logic                  q_out_valid;
  logic [12:0]           q_out_data;
  logic [12:0]           push_data;
  logic [2:0]            level;
  logic                  raw_int;
  logic                  int_status;
  logic [2:0]            next_select;
  logic [8:0]            acc_sum;

  assign wr_cs    = reg_req.wr && (reg_req.addr == `OFS_CONTROL_STATUS);
  assign wr_qc    = reg_req.wr && (reg_req.addr == `OFS_QUEUE_CTRL);
  assign wr_div   = reg_req.wr && (reg_req.addr == `OFS_PACING_DIVIDER);
  assign rd_qdata = reg_req.rd && (reg_req.addr == `OFS_QUEUE_DATA);

  // Next masked input after the current one, wrapping
  always_comb begin
    next_select = input_select_q;
    for (int k = 5; k >= 1; k--) begin
      if (rotation_channel_mask_q[(32'(input_select_q) + k) % 5]) begin
        next_select = 3'((32'(input_select_q) + k) % 5);
      end
    end
  end

  // Conversion sequencing and power-up
  assign ready = (state_q == ST_IDLE);
  assign done  = (state_q == ST_BUSY) && (conv_cnt_q == `CONV_CYCLES - 7'd1);
  // Paced trigger is ignored while a conversion runs
  assign start = ready && ((many_q && (({div_int_q, div_frac_q} == '0) || pace_tick)) ||
                           (wr_cs && reg_req.wdata[`CS_START_ONCE] && !many_q &&
                            !reg_req.wdata[`CS_START_MANY]));

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q    <= ST_OFF;
      pwr_cnt_q  <= '0;
      conv_cnt_q <= '0;
    end else begin
      case (state_q)
        ST_OFF: begin
          pwr_cnt_q <= '0;
          if (en_q) begin
            state_q <= ST_POWERUP;
          end
        end
        ST_POWERUP: begin
          pwr_cnt_q <= pwr_cnt_q + 3'd1;
          if (!en_q) begin
            state_q <= ST_OFF;
          end else if (pwr_cnt_q == `POWERUP_CYCLES - 3'd1) begin
            state_q <= ST_IDLE;
          end
        end
        ST_IDLE: begin
          conv_cnt_q <= '0;
          if (!en_q) begin
            state_q <= ST_OFF;
          end else if (start) begin
            state_q <= ST_BUSY;
          end
        end
        ST_BUSY: begin
          conv_cnt_q <= conv_cnt_q + 7'd1;
          if (done) begin
            state_q <= en_q ? ST_IDLE : ST_OFF;
          end
        end
        default: begin
          state_q <= ST_OFF;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sar_start_q <= 1'b0;
    end else begin
      sar_start_q <= start;
    end
  end

  // Pacing divider; fraction spreads intervals between int+1 and int+2
  assign acc_sum    = {1'b0, pace_acc_q} + {1'b0, div_frac_q};
  assign pace_extra = acc_sum[8];
  assign pace_tick  = (pace_cnt_q == {1'b0, div_int_q} + {16'h0000, pace_extra});

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pace_cnt_q <= '0;
      pace_acc_q <= '0;
    end else if (wr_div || !many_q) begin
      pace_cnt_q <= '0;
      pace_acc_q <= '0;
    end else if (pace_tick) begin
      pace_cnt_q <= '0;
      pace_acc_q <= acc_sum[7:0];
    end else begin
      pace_cnt_q <= pace_cnt_q + 17'h00001;
    end
  end

  // Control/status register; a completing conversion's select update beats a write
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      en_q                    <= 1'b0;
      temp_bias_enable_q      <= 1'b0;
      many_q                  <= 1'b0;
      input_select_q          <= '0;
      rotation_channel_mask_q <= '0;
    end else begin
      if (wr_cs) begin
        en_q                    <= reg_req.wdata[`CS_EN];
        temp_bias_enable_q      <= reg_req.wdata[`CS_TEMP_BIAS_ENABLE];
        many_q                  <= reg_req.wdata[`CS_START_MANY];
        input_select_q          <= reg_req.wdata[`CS_SEL_MSB:`CS_SEL_LSB];
        rotation_channel_mask_q <= reg_req.wdata[`CS_MASK_MSB:`CS_MASK_LSB];
      end
      if (done && many_q && (rotation_channel_mask_q != '0)) begin
        input_select_q <= next_select;
      end
    end
  end

  // Latest result and error flags
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      result_q     <= '0;
      err_q        <= 1'b0;
      err_sticky_q <= 1'b0;
    end else begin
      if (done) begin
        result_q <= sar_sample.data;
        err_q    <= sar_sample.err;
      end
      if (done && sar_sample.err) begin
        err_sticky_q <= 1'b1;
      end else if (wr_cs && reg_req.wdata[`CS_ERR_STICKY]) begin
        err_sticky_q <= 1'b0;
      end
    end
  end

  // Queue entry shaping
  always_comb begin
    push_data = {1'b0, sar_sample.data};
    if (byte_shift_option_q) begin
      push_data = {5'h00, sar_sample.data[11:4]};
    end
    if (error_tag_option_q) begin
      push_data[`ENTRY_ERR_BIT] = sar_sample.err;
    end
  end

  assign push_req = done && queue_write_enable_q;

  result_queue #(
    .WIDTH (13),
    .DEPTH (`QUEUE_DEPTH)
  ) u_queue (
    .clk       (clk),
    .arst_n    (arst_n),
    .in_valid  (push_req),
    .in_ready  (q_in_ready),
    .in_data   (push_data),
    .out_valid (q_out_valid),
    .out_ready (rd_qdata),
    .out_data  (q_out_data),
    .level     (level)
  );

  // Queue control; hardware set wins over write-one-to-clear
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      queue_write_enable_q   <= 1'b0;
      byte_shift_option_q    <= 1'b0;
      error_tag_option_q     <= 1'b0;
      dma_request_enable_q   <= 1'b0;
      queue_threshold_q      <= '0;
      queue_overflow_flag_q  <= 1'b0;
      queue_underflow_flag_q <= 1'b0;
    end else begin
      if (wr_qc) begin
        queue_write_enable_q <= reg_req.wdata[`QC_EN];
        byte_shift_option_q  <= reg_req.wdata[`QC_SHIFT];
        error_tag_option_q   <= reg_req.wdata[`QC_ERR];
        dma_request_enable_q <= reg_req.wdata[`QC_DREQ_EN];
        queue_threshold_q    <= reg_req.wdata[`QC_THRESH_MSB:`QC_THRESH_LSB];
      end
      if (push_req && !q_in_ready) begin
        queue_overflow_flag_q <= 1'b1;
      end else if (wr_qc && reg_req.wdata[`QC_OVER]) begin
        queue_overflow_flag_q <= 1'b0;
      end
      if (rd_qdata && !q_out_valid) begin
        queue_underflow_flag_q <= 1'b1;
      end else if (wr_qc && reg_req.wdata[`QC_UNDER]) begin
        queue_underflow_flag_q <= 1'b0;
      end
    end
  end

  // Divider and interrupt registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      div_int_q  <= '0;
      div_frac_q <= '0;
      interrupt_enable_q     <= 1'b0;
      interrupt_force_q     <= 1'b0;
    end else begin
      if (wr_div) begin
        div_int_q  <= reg_req.wdata[`DIV_INT_MSB:`DIV_INT_LSB];
        div_frac_q <= reg_req.wdata[`DIV_FRAC_MSB:`DIV_FRAC_LSB];
      end
      if (reg_req.wr && (reg_req.addr == `OFS_INTERRUPT_ENABLE)) begin
        interrupt_enable_q <= reg_req.wdata[0];
      end
      if (reg_req.wr && (reg_req.addr == `OFS_INTERRUPT_FORCE)) begin
        interrupt_force_q <= reg_req.wdata[0];
      end
    end
  end

  // Level condition is live, so draining clears it without acknowledge
  assign raw_int    = ({1'b0, level} >= queue_threshold_q);
  assign int_status = (raw_int && interrupt_enable_q) || interrupt_force_q;

  // Register read port, answer one cycle after the strobe
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_q  <= '0;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= reg_req.rd;
      rdata_q  <= '0;
      if (reg_req.rd) begin
        case (reg_req.addr)
          `OFS_CONTROL_STATUS: begin
            rdata_q[`CS_MASK_MSB:`CS_MASK_LSB] <= rotation_channel_mask_q;
            rdata_q[`CS_SEL_MSB:`CS_SEL_LSB]   <= input_select_q;
            rdata_q[`CS_ERR_STICKY]            <= err_sticky_q;
            rdata_q[`CS_ERR]                   <= err_q;
            rdata_q[`CS_READY]                 <= ready;
            rdata_q[`CS_START_MANY]            <= many_q;
            rdata_q[`CS_TEMP_BIAS_ENABLE]                 <= temp_bias_enable_q;
            rdata_q[`CS_EN]                    <= en_q;
          end
          `OFS_LATEST_RESULT: begin
            rdata_q[11:0] <= result_q;
          end
          `OFS_QUEUE_CTRL: begin
            rdata_q[`QC_THRESH_MSB:`QC_THRESH_LSB] <= queue_threshold_q;
            rdata_q[`QC_LEVEL_MSB:`QC_LEVEL_LSB]   <= {1'b0, level};
            rdata_q[`QC_OVER]                      <= queue_overflow_flag_q;
            rdata_q[`QC_UNDER]                     <= queue_underflow_flag_q;
            rdata_q[`QC_FULL]                      <= !q_in_ready;
            rdata_q[`QC_EMPTY]                     <= !q_out_valid;
            rdata_q[`QC_DREQ_EN]                   <= dma_request_enable_q;
            rdata_q[`QC_ERR]                       <= error_tag_option_q;
            rdata_q[`QC_SHIFT]                     <= byte_shift_option_q;
            rdata_q[`QC_EN]                        <= queue_write_enable_q;
          end
          `OFS_QUEUE_DATA: begin
            rdata_q[12:0] <= q_out_valid ? q_out_data : 13'h0000;
          end
          `OFS_PACING_DIVIDER: begin
            rdata_q[`DIV_INT_MSB:`DIV_INT_LSB]   <= div_int_q;
            rdata_q[`DIV_FRAC_MSB:`DIV_FRAC_LSB] <= div_frac_q;
          end
          `OFS_RAW_INTERRUPT: begin
            rdata_q[0] <= raw_int;
          end
          `OFS_INTERRUPT_ENABLE: begin
            rdata_q[0] <= interrupt_enable_q;
          end
          `OFS_INTERRUPT_FORCE: begin
            rdata_q[0] <= interrupt_force_q;
          end
          `OFS_INTERRUPT_STATUS: begin
            rdata_q[0] <= int_status;
          end
          default: begin
            rdata_q <= '0;
          end
        endcase
      end
    end
  end

  assign reg_rvalid            = rvalid_q;
  assign reg_rdata             = rdata_q;
  assign converter_power       = en_q;
  assign temp_bias_enable      = temp_bias_enable_q;
  assign sar_start             = sar_start_q;
  assign sar_select            = input_select_q;
  assign converter_dma_request = dma_request_enable_q && raw_int;
  assign irq                   = int_status;

  rr_step_a: assert property (@(posedge clk) disable iff (!arst_n)
    done && many_q && !wr_cs && (rotation_channel_mask_q != '0) |=> rotation_channel_mask_q[input_select_q])
    else $error("select did not land on a masked input");

  sel_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
    !many_q && !wr_cs |=> $stable(input_select_q))
    else $error("select moved outside free-running capture");

  rr_off_a: assert property (@(posedge clk) disable iff (!arst_n)
    (rotation_channel_mask_q == '0) && !wr_cs |=> $stable(input_select_q))
    else $error("select moved with empty mask");

  conv_len_a: assert property (@(posedge clk) disable iff (!arst_n)
    sar_start |-> ##95 done)
    else $error("conversion did not finish after 96 cycles");

  conv_origin_a: assert property (@(posedge clk) disable iff (!arst_n)
    done |-> $past(sar_start, 95))
    else $error("conversion finished early");

  over_drop_a: assert property (@(posedge clk) disable iff (!arst_n)
    push_req && !q_in_ready && !rd_qdata |=> queue_overflow_flag_q && $stable(level))
    else $error("overflow not flagged or queue changed");

  shift_data_a: assert property (@(posedge clk) disable iff (!arst_n)
    push_req && q_in_ready && byte_shift_option_q && (level == 3'd0) && !rd_qdata
      |=> q_out_data[7:0] == $past(sar_sample.data[11:4]))
    else $error("byte shift entry wrong");

  dreq_gate_a: assert property (@(posedge clk) disable iff (!arst_n)
    !dma_request_enable_q || ({1'b0, level} < queue_threshold_q) |-> !converter_dma_request)
    else $error("dma request without enable");

  under_set_a: assert property (@(posedge clk) disable iff (!arst_n)
    rd_qdata && !q_out_valid |=> queue_underflow_flag_q)
    else $error("underflow not flagged");

  irq_drain_a: assert property (@(posedge clk) disable iff (!arst_n)
    !interrupt_force_q && ({1'b0, level} < queue_threshold_q) |-> !irq)
    else $error("interrupt held below threshold");

  div_reset_a: assert property (@(posedge clk) disable iff (!arst_n)
    wr_div |=> pace_cnt_q == 17'h00000)
    else $error("pacing counter not reset by divider write");
endmodule : adc_sequencer
`default_nettype wire

// file: verification/sar_core_model.sv
// Behavioural analogue converter core answering start pulses
`default_nettype none
module sar_core_model (
  input  wire logic            clk,
  input  wire logic            arst_n,
  input  wire logic            sar_start,
  input  wire logic [2:0]      sar_select,
  input  wire logic            err_en,
  output adc_ctrl_pkg::sample_s sar_sample
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [6:0]            age_q;
  logic [3:0]            cnt_q;
  adc_ctrl_pkg::sample_s hold_q;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      age_q <= 7'h7F;
      cnt_q <= 4'h0;
      hold_q <= '0;
    end else if (sar_start) begin
      age_q <= 7'h00;
      cnt_q <= cnt_q + 4'h1;
      hold_q <= {err_en & cnt_q[0], cnt_q, 1'h0, sar_select, 4'hB};
    end else if (age_q != 7'h7F) begin
      age_q <= age_q + 7'h01;
    end
  end
  // Result valid only around the end of the conversion; garbage otherwise
  assign sar_sample = (age_q >= 7'd90 && age_q <= 7'd100) ? hold_q : ~hold_q;
endmodule : sar_core_model
`default_nettype wire

// file: verification/adc_sequencer_tb.sv
// Self-checking bench for the converter sequencer
`include "adc_ctrl_map.svh"
`default_nettype none
module adc_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [5:0]  addr;
    logic [31:0] exp;
  } row_s;
  logic                   clk;
  logic                   arst_n;
  adc_ctrl_pkg::reg_req_s reg_req;
  logic                   reg_rvalid;
  logic [31:0]            reg_rdata;
  logic                   converter_power;
  logic                   temp_bias_enable;
  logic                   sar_start;
  logic [2:0]             sar_select;
  adc_ctrl_pkg::sample_s  sar_sample;
  logic                   converter_dma_request;
  logic                   irq;
  logic                   err_en;
  int                     miscompares;
  int                     comparisons;
  int                     gap;
  int                     seen;
  logic [31:0]            rd;
  row_s                   rows [10];
  logic [2:0]             seq [4];
  adc_sequencer uut (.clk(clk), .arst_n(arst_n), .reg_req(reg_req), .reg_rvalid(reg_rvalid),
    .reg_rdata(reg_rdata), .converter_power(converter_power), .temp_bias_enable(temp_bias_enable),
    .sar_start(sar_start), .sar_select(sar_select), .sar_sample(sar_sample),
    .converter_dma_request(converter_dma_request), .irq(irq));
  sar_core_model core (.clk(clk), .arst_n(arst_n), .sar_start(sar_start), .sar_select(sar_select),
    .err_en(err_en), .sar_sample(sar_sample));
  always #2 clk = ~clk;
  function automatic logic [11:0] conv(input int k, input logic [2:0] s);
    conv = {k[3:0], 1'h0, s, 4'hB};
  endfunction : conv
  task automatic check_word(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check_word
  task automatic reg_write(input logic [5:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_req <= '{wr: 1'h1, rd: 1'h0, addr: a, wdata: d};
    @(posedge clk);
    reg_req <= '0;
  endtask : reg_write
  task automatic reg_read(input logic [5:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_req <= '{wr: 1'h0, rd: 1'h1, addr: a, wdata: 32'h0};
    @(posedge clk);
    reg_req <= '0;
    @(posedge clk);
    check_word({31'h0, reg_rvalid}, 32'h1, "read answer");
    d = reg_rdata;
  endtask : reg_read
  task automatic rd_check(input logic [5:0] a, input logic [31:0] exp, input string what);
    logic [31:0] v;
    reg_read(a, v);
    check_word(v, exp, what);
  endtask : rd_check
  task automatic poll(input logic [5:0] a, input int b);
    logic [31:0] v = '0;
    for (int i = 0; i < 300 && v[b] !== 1'h1; i++) reg_read(a, v);
    check_word({31'h0, v[b]}, 32'h1, "status wait");
  endtask : poll
  task automatic complete_run;
    $display("counts: %0d comparisons, %0d miscompares", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run
  initial begin
    #80000;
    miscompares++;
    complete_run();
  end
  initial begin
    clk = 1'h0;
    arst_n = 1'h0;
    reg_req = '0;
    err_en = 1'h0;
    miscompares = 0;
    comparisons = 0;
    seq = '{3'h0, 3'h1, 3'h2, 3'h1};
    for (int i = 0; i < 10; i++) rows[i] = '{addr: 6'(i * 4), exp: 32'h0};
    // Empty queue shows EMPTY; zero threshold makes the raw condition true
    rows[2].exp = 32'h00000100;
    rows[5].exp = 32'h00000001;
    repeat (12) @(posedge clk);
    arst_n <= 1'h1;
    foreach (rows[i]) rd_check(rows[i].addr, rows[i].exp, "reset value");
    // The row reading the empty queue leaves underflow set
    rd_check(`OFS_QUEUE_CTRL, 32'h00000500, "reset underflow");
    reg_write(`OFS_QUEUE_CTRL, 32'h00000400);
    check_word({30'h0, irq, converter_dma_request}, 32'h0, "idle request");
    $display("test reset done");
    reg_write(`OFS_CONTROL_STATUS, 32'h00000001);
    poll(`OFS_CONTROL_STATUS, 8);
    check_word({31'h0, converter_power}, 32'h1, "power");
    // Single conversion on the temperature input, mask set but ignored
    reg_write(`OFS_CONTROL_STATUS, 32'h00064007);
    @(posedge clk);
    check_word({28'h0, temp_bias_enable, sar_select}, 32'hC, "temp route");
    poll(`OFS_CONTROL_STATUS, 8);
    rd_check(`OFS_LATEST_RESULT, {20'h0, conv(0, 3'h4)}, "latest");
    rd_check(`OFS_CONTROL_STATUS, 32'h00064103, "select kept");
    $display("test one-shot done");
    // Byte transfer setup: shift, request enable, threshold one
    reg_write(`OFS_QUEUE_CTRL, 32'h0100000B);
    reg_write(`OFS_CONTROL_STATUS, 32'h00064007);
    poll(`OFS_CONTROL_STATUS, 8);
    check_word({31'h0, converter_dma_request}, 32'h1, "one sample request");
    rd_check(`OFS_QUEUE_DATA, {20'h0, conv(1, 3'h4) >> 4}, "shifted");
    rd_check(`OFS_QUEUE_CTRL, 32'h0100010B, "drained");
    $display("test byte shift done");
    // Rate first, then queue and request, then free-running start
    reg_write(`OFS_PACING_DIVIDER, 32'h0);
    reg_write(`OFS_QUEUE_CTRL, 32'h0200000D);
    reg_write(`OFS_INTERRUPT_ENABLE, 32'h1);
    err_en <= 1'h1;
    reg_write(`OFS_CONTROL_STATUS, 32'h00060009);
    poll(`OFS_QUEUE_CTRL, 9);
    repeat (100) @(posedge clk);
    check_word({30'h0, irq, converter_dma_request}, 32'h3, "at threshold");
    rd_check(`OFS_RAW_INTERRUPT, 32'h1, "raw");
    rd_check(`OFS_INTERRUPT_STATUS, 32'h1, "status");
    reg_write(`OFS_CONTROL_STATUS, 32'h00060001);
    poll(`OFS_CONTROL_STATUS, 8);
    rd_check(`OFS_QUEUE_CTRL, 32'h02040A0D, "overflow");
    for (int j = 0; j < 4; j++) begin
      rd_check(`OFS_QUEUE_DATA, {19'h0, 1'(j % 2), conv(j + 2, seq[j])}, "entry");
      check_word({31'h0, converter_dma_request}, {31'h0, 1'(j < 2)}, "drain request");
    end
    check_word({31'h0, irq}, 32'h0, "irq dropped");
    reg_read(`OFS_CONTROL_STATUS, rd);
    check_word({31'h0, rd[10]}, 32'h1, "error sticky");
    rd_check(`OFS_QUEUE_DATA, 32'h0, "empty read");
    rd_check(`OFS_QUEUE_CTRL, 32'h02000D0D, "underflow");
    reg_write(`OFS_QUEUE_CTRL, 32'h02000C0D);
    rd_check(`OFS_QUEUE_CTRL, 32'h0200010D, "flags cleared");
    $display("test free-running done");
    reg_write(`OFS_INTERRUPT_FORCE, 32'h1);
    rd_check(`OFS_RAW_INTERRUPT, 32'h0, "raw low");
    rd_check(`OFS_INTERRUPT_STATUS, 32'h1, "forced");
    check_word({31'h0, irq}, 32'h1, "forced line");
    reg_write(`OFS_INTERRUPT_FORCE, 32'h0);
    @(posedge clk);
    check_word({31'h0, irq}, 32'h0, "unforced");
    $display("test force done");
    // Paced capture: integer 199, fraction one half, gaps alternate 201 and 200
    reg_write(`OFS_PACING_DIVIDER, 32'h0000C780);
    reg_write(`OFS_CONTROL_STATUS, 32'h00000009);
    gap = 0;
    seen = 0;
    while (seen < 3 && gap < 1000) begin
      @(posedge clk);
      gap++;
      if (sar_start === 1'h1) begin
        if (seen == 1) check_word(32'(gap), 32'h000000C9, "paced gap");
        if (seen == 2) check_word(32'(gap), 32'h000000C8, "paced gap");
        seen++;
        gap = 0;
      end
    end
    check_word(32'(seen), 32'h00000003, "paced starts");
    $display("test paced done");
    complete_run();
  end
endmodule : adc_sequencer_tb
`default_nettype wire
